// [logic/twm_map.vh]
// register offsets, field positions, reset values and constants of the timing/watchdog unit
`ifndef TIMING_WATCHDOG_MAP_VH
`define TIMING_WATCHDOG_MAP_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_CONFIG_LOCK      3'h0
`define OFS_TICK_PRESCALER   3'h1
`define OFS_TIMER_RELOAD     3'h2
`define OFS_TIMER_CTRL       3'h3
`define OFS_WATCHDOG_COUNT   3'h4
`define OFS_SERVICE_MATCH    3'h5

// ------------------------------------------------------------
// config_lock fields
// ------------------------------------------------------------
`define CFG_LOCK_CONFIG      0
`define CFG_LOCK_PRESCALER   1
`define CFG_LOCK_TIMER       2
`define CFG_LOCK_WD_COUNT    3
`define CFG_WD_FROM_TICK     4
`define CFG_MATCH_SERVICE    5
`define CFG_USED_MASK        8'h3F

// ------------------------------------------------------------
// timer_ctrl_status fields
// ------------------------------------------------------------
`define CSR_RESTART          0
`define CSR_COUNT_FLAG       1
`define CSR_IRQ_ENABLE       2

// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define RST_CONFIG_LOCK      8'h00
`define RST_TICK_DIVIDER     3'h0
`define RST_TIMER_RELOAD     16'hFFFF
`define RST_WATCHDOG_COUNT   8'h0F
`define SERVICE_MATCH_BYTE   8'h5C
`define DIV_CODE_MAX         3'h5

`endif

// [logic/timing_watchdog_unit.v]
// timing and watchdog unit: prescaler, reload timer and watchdog with register locks
//
// Added by the designer: the strobed register port and the address map.
`include "twm_map.vh"

// How it works
// - config bits clear at reset, sticky once set
// - locked registers ignore writes, read zero
// - bits 0..3 lock config, prescaler, timer, count
// - bit 4 picks tick or terminal pulse
// - bit 5 picks match-byte or count servicing
// - divider code 0..5 divides by 1..32
// - reload resets FFFF, loads on each underflow
// - restart reloads on next tick, self-clears
// - terminal flag set at zero, read clears
// - irq enable gates timer interrupt
// - count resets 0F; write starts watchdog, restarts it only when match servicing is off
// - match byte reloads last written count
// - wrong match byte raises watchdog error
// - two matches per watchdog clock error
// - match writes ignored when match disabled
// - 8-bit down counter, idle until started
// - any watchdog error resets the device
// - timer counts down per tick, auto-reloads
// - terminal pulse high one tick period
module timing_watchdog_unit (
    input  wire        clk,
    input  wire        rst,
    input  wire        slow_clock,
    input  wire [2:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    output reg         timer_irq,
    output reg         watchdog_reset,
    output reg         terminal_pulse,
    output reg         prescaled_tick
);

// ------------------------------------------------------------
// slow clock synchroniser and edge detect
// ------------------------------------------------------------
reg       slow_meta_q;
reg       slow_sync_q;
reg       slow_prev_q;
wire      slow_rise = slow_sync_q & ~slow_prev_q;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        slow_meta_q <= 1'b0;
        slow_sync_q <= 1'b0;
        slow_prev_q <= 1'b0;
    end else begin
        slow_meta_q <= slow_clock;
        slow_sync_q <= slow_meta_q;
        slow_prev_q <= slow_sync_q;
    end
end

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg  [7:0]  config_lock_q;
reg  [2:0]  tick_divider_q;
reg  [15:0] timer_reload_q;
reg         restart_q;
reg         terminal_count_flag_q;
reg         timer_irq_enable_q;
reg  [7:0]  watchdog_count_q;

wire lock_config   = config_lock_q[`CFG_LOCK_CONFIG];
wire lock_prescaler = config_lock_q[`CFG_LOCK_PRESCALER];
wire lock_timer    = config_lock_q[`CFG_LOCK_TIMER];
wire lock_wd_count = config_lock_q[`CFG_LOCK_WD_COUNT];
wire wd_clock_from_tick   = config_lock_q[`CFG_WD_FROM_TICK];
wire match_service_enable = config_lock_q[`CFG_MATCH_SERVICE];

wire wr_config  = wr & (addr == `OFS_CONFIG_LOCK) & ~lock_config;
wire wr_presc   = wr & (addr == `OFS_TICK_PRESCALER) & ~lock_prescaler;
wire wr_reload  = wr & (addr == `OFS_TIMER_RELOAD) & ~lock_timer;
wire wr_ctrl    = wr & (addr == `OFS_TIMER_CTRL) & ~lock_timer;
wire wr_count   = wr & (addr == `OFS_WATCHDOG_COUNT) & ~lock_wd_count;
wire wr_match   = wr & (addr == `OFS_SERVICE_MATCH) & match_service_enable;
wire rd_ctrl    = rd & (addr == `OFS_TIMER_CTRL) & ~lock_timer;

// ------------------------------------------------------------
// prescaler
// ------------------------------------------------------------
reg  [4:0] presc_cnt_q;
reg  [4:0] div_limit;
wire       tick;

always @* begin
    case (tick_divider_q)
        3'h0:    div_limit = 5'h00;
        3'h1:    div_limit = 5'h01;
        3'h2:    div_limit = 5'h03;
        3'h3:    div_limit = 5'h07;
        3'h4:    div_limit = 5'h0F;
        3'h5:    div_limit = 5'h1F;
        default: div_limit = 5'h00;
    endcase
end

assign tick = slow_rise & (presc_cnt_q >= div_limit);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        presc_cnt_q    <= 5'h00;
        prescaled_tick <= 1'b0;
    end else begin
        if (slow_rise) begin
            if (presc_cnt_q >= div_limit) begin
                presc_cnt_q <= 5'h00;
            end else begin
                presc_cnt_q <= presc_cnt_q + 5'h01;
            end
        end
        if (tick) begin
            prescaled_tick <= 1'b1;
        end else if (slow_rise && presc_cnt_q == {1'b0, div_limit[4:1]}) begin
            prescaled_tick <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// timer
// ------------------------------------------------------------
reg  [15:0] timer_cnt_q;
wire        timer_zero = tick & ~restart_q & (timer_cnt_q == 16'h0001);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        timer_cnt_q    <= `RST_TIMER_RELOAD;
        terminal_pulse <= 1'b0;
        timer_irq      <= 1'b0;
    end else begin
        if (tick) begin
            if (restart_q || timer_cnt_q == 16'h0000) begin
                timer_cnt_q <= timer_reload_q;
            end else begin
                timer_cnt_q <= timer_cnt_q - 16'h0001;
            end
            terminal_pulse <= timer_zero;
        end
        timer_irq <= timer_zero & timer_irq_enable_q;
    end
end

// ------------------------------------------------------------
// register writes
// ------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        config_lock_q         <= `RST_CONFIG_LOCK;
        tick_divider_q        <= `RST_TICK_DIVIDER;
        timer_reload_q        <= `RST_TIMER_RELOAD;
        restart_q             <= 1'b0;
        terminal_count_flag_q <= 1'b0;
        timer_irq_enable_q    <= 1'b0;
        watchdog_count_q      <= `RST_WATCHDOG_COUNT;
    end else begin
        if (wr_config) begin
            config_lock_q <= config_lock_q | (wdata[7:0] & `CFG_USED_MASK);
        end
        if (wr_presc) begin
            tick_divider_q <= wdata[2:0];
        end
        if (wr_reload) begin
            timer_reload_q <= wdata;
        end
        if (wr_ctrl) begin
            timer_irq_enable_q <= wdata[`CSR_IRQ_ENABLE];
        end
        if (wr_ctrl && wdata[`CSR_RESTART]) begin
            restart_q <= 1'b1;
        end else if (tick) begin
            restart_q <= 1'b0;
        end
        if (timer_zero) begin
            terminal_count_flag_q <= 1'b1;
        end else if (rd_ctrl) begin
            terminal_count_flag_q <= 1'b0;
        end
        if (wr_count) begin
            watchdog_count_q <= wdata[7:0];
        end
    end
end

// ------------------------------------------------------------
// watchdog
// ------------------------------------------------------------
reg  [7:0] wd_cnt_q;
reg        wd_run_q;
reg        match_seen_q;
wire       wd_clk_ev = wd_clock_from_tick ? tick : timer_zero;
wire       match_ok  = wr_match & (wdata[7:0] == `SERVICE_MATCH_BYTE);
wire       match_bad = wr_match & (wdata[7:0] != `SERVICE_MATCH_BYTE);
wire       match_dup = match_ok & match_seen_q & ~wd_clk_ev;
wire       wd_expire = wd_run_q & wd_clk_ev & (wd_cnt_q == 8'h01);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        wd_cnt_q       <= `RST_WATCHDOG_COUNT;
        wd_run_q       <= 1'b0;
        match_seen_q   <= 1'b0;
        watchdog_reset <= 1'b0;
    end else begin
        if (wr_count && !match_service_enable) begin
            wd_cnt_q <= wdata[7:0];
            wd_run_q <= 1'b1;
        end else if (wr_count && !wd_run_q) begin
            wd_cnt_q <= wdata[7:0];
            wd_run_q <= 1'b1;
        end else if (match_ok) begin
            wd_cnt_q <= watchdog_count_q;
            wd_run_q <= 1'b1;
        end else if (wd_run_q && wd_clk_ev && wd_cnt_q != 8'h00) begin
            wd_cnt_q <= wd_cnt_q - 8'h01;
        end
        if (match_ok) begin
            match_seen_q <= 1'b1;
        end else if (wd_clk_ev) begin
            match_seen_q <= 1'b0;
        end
        watchdog_reset <= wd_expire | match_bad | match_dup;
    end
end

// ------------------------------------------------------------
// register reads
// ------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        rdata <= 16'h0000;
    end else begin
        rdata <= 16'h0000;
        if (rd) begin
            case (addr)
                `OFS_CONFIG_LOCK: begin
                    if (!lock_config) rdata <= {8'h00, config_lock_q};
                end
                `OFS_TICK_PRESCALER: begin
                    if (!lock_prescaler) rdata <= {13'h0000, tick_divider_q};
                end
                `OFS_TIMER_RELOAD: begin
                    if (!lock_timer) rdata <= timer_reload_q;
                end
                `OFS_TIMER_CTRL: begin
                    if (!lock_timer) rdata <= {13'h0000, timer_irq_enable_q,
                                               terminal_count_flag_q, restart_q};
                end
                default: rdata <= 16'h0000;
            endcase
        end
    end
end

endmodule // timing_watchdog_unit

// [testbench/twm_asserts.sv]
// checker for the register port and event outputs of the timing/watchdog unit
module timing_watchdog_asserts (
    input wire        clk,
    input wire        rst,
    input wire [2:0]  addr,
    input wire [15:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [15:0] rdata,
    input wire        timer_irq,
    input wire        watchdog_reset,
    input wire        terminal_pulse
);
    reg [7:0] cfg_q;
    reg       ien_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= 8'h00;
            ien_q <= 1'b0;
        end else begin
            if (wr && addr == 3'h0 && !cfg_q[0])
                cfg_q <= cfg_q | (wdata[7:0] & 8'h3F);
            if (wr && addr == 3'h3 && !cfg_q[2])
                ien_q <= wdata[2];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence bad_match_s;
        wr && addr == 3'h5 && cfg_q[5] && wdata[7:0] != 8'h5C;
    endsequence
    sequence wd_fire_s;
        ##[1:3] watchdog_reset;
    endsequence
    a_bad_match_error: assert property (bad_match_s |-> wd_fire_s)
        else $error("no watchdog error after wrong match byte");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read answer");
    a_wo_read_zero: assert property (rd && addr >= 3'h4 |=> rdata == 16'h0000)
        else $error("write-only or unmapped read not zero");
    a_cfg_read_back: assert property (rd && addr == 3'h0 && !cfg_q[0] |=>
        rdata == {8'h00, $past(cfg_q)}) else $error("config read mismatch");
    a_cfg_locked_read: assert property (rd && addr == 3'h0 && cfg_q[0] |=>
        rdata == 16'h0000) else $error("locked config read not zero");
    a_irq_single: assert property (timer_irq |=> !timer_irq)
        else $error("timer interrupt longer than one cycle");
    a_irq_disabled: assert property (!ien_q && !$past(ien_q) |-> !timer_irq)
        else $error("timer interrupt while disabled");
    a_irq_with_pulse: assert property (timer_irq |-> terminal_pulse || $past(terminal_pulse))
        else $error("interrupt without terminal pulse");
    a_wd_single: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("watchdog error longer than one cycle");
endmodule // timing_watchdog_asserts

bind timing_watchdog_unit timing_watchdog_asserts u_chk (.clk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .timer_irq, .watchdog_reset, .terminal_pulse);

// [testbench/test_timing_watchdog_unit.sv]
// self-checking bench for the timing/watchdog unit
`include "twm_map.vh"
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_timing_watchdog_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, slow_clock = 0, wr = 0, rd = 0;
    logic [2:0]  addr = 3'h0;
    logic [1:0]  sdiv = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata, d;
    logic        timer_irq, watchdog_reset, terminal_pulse, prescaled_tick;
    logic [15:0] ex [0:6] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    int          n_fail = 0, n_compared = 0, cyc = 0, n;
    timing_watchdog_unit uut (.clk, .rst, .slow_clock, .addr, .wdata, .wr, .rd, .rdata,
        .timer_irq, .watchdog_reset, .terminal_pulse, .prescaled_tick);
    always #25 clk = ~clk;
    // slow clock: period of 8 system clocks
    always @(posedge clk) begin
        sdiv <= sdiv + 2'h1;
        if (sdiv == 2'h3) slow_clock <= ~slow_clock;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict;
        end
    end
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask
    // cycles until interrupt (w=0) or watchdog error (w=1), -1 if none
    task automatic wait_ev(input bit w, input int lim, output int c);
        c = -1;
        for (int i = 1; i <= lim && c < 0; i++) begin
            #1;
            if ((w ? watchdog_reset : timer_irq) === 1'b1) c = i;
            @(posedge clk);
        end
    endtask
    task automatic t_reset_values;
        for (int a = 0; a < 7; a++) begin
            rd_reg(3'(a), d);
            `CHECK("reset value", ex[a], d)
        end
    endtask
    task automatic t_periods;
        wr_reg(`OFS_TIMER_RELOAD, 16'h0001);
        wr_reg(`OFS_TIMER_CTRL, 16'h0005);
        for (int k = 0; k < 6; k++) begin
            wr_reg(`OFS_TICK_PRESCALER, 16'(k));
            wait_ev(0, 2000, n);
            wait_ev(0, 2000, n);
            wait_ev(0, 2000, n);
            `CHECK("timer period", 16 << k, n)
            #1;
            `CHECK("terminal pulse", 1'b1, terminal_pulse)
            if (k == 0) `CHECK("prescaled tick", 1'b1, prescaled_tick)
        end
        rd_reg(`OFS_TIMER_CTRL, d);
        `CHECK("flag set", 16'h0006, d)
        rd_reg(`OFS_TIMER_CTRL, d);
        `CHECK("flag cleared", 16'h0004, d)
        wr_reg(`OFS_TIMER_CTRL, 16'h0006);
        rd_reg(`OFS_TIMER_CTRL, d);
        `CHECK("flag write", 16'h0004, d)
        wr_reg(`OFS_TIMER_CTRL, 16'h0000);
        wait_ev(0, 1200, n);
        `CHECK("irq disabled", -1, n)
    endtask
    task automatic t_watchdog;
        wr_reg(`OFS_TICK_PRESCALER, 16'h0000);
        wr_reg(`OFS_CONFIG_LOCK, 16'h0010);
        wait_ev(1, 100, n);
        `CHECK("idle watchdog", -1, n)
        for (int k = 0; k < 4; k++) begin
            wr_reg(`OFS_WATCHDOG_COUNT, 16'h0005);
            wr_reg(`OFS_SERVICE_MATCH, 16'h0011);
            wait_ev(1, 20, n);
            `CHECK("count service", -1, n)
        end
        wait_ev(1, 80, n);
        `CHECK("expiry", 1'b1, n > 0)
        wr_reg(`OFS_CONFIG_LOCK, 16'h0030);
        wr_reg(`OFS_TICK_PRESCALER, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            wr_reg(`OFS_SERVICE_MATCH, 16'h005C);
            wait_ev(1, 20, n);
            `CHECK("match service", -1, n)
        end
        // both writes land well inside one watchdog clock cycle
        @(posedge prescaled_tick);
        wr_reg(`OFS_SERVICE_MATCH, 16'h005C);
        wr_reg(`OFS_SERVICE_MATCH, 16'h005C);
        wait_ev(1, 4, n);
        `CHECK("double match", 1'b1, n > 0)
        repeat (16) @(posedge clk);
        wr_reg(`OFS_SERVICE_MATCH, 16'h00A3);
        wait_ev(1, 4, n);
        `CHECK("wrong match", 1'b1, n > 0)
    endtask
    task automatic t_locks;
        wr_reg(`OFS_CONFIG_LOCK, 16'h0000);
        rd_reg(`OFS_CONFIG_LOCK, d);
        `CHECK("sticky config", 16'h0030, d)
        wr_reg(`OFS_CONFIG_LOCK, 16'h00CE);
        rd_reg(`OFS_CONFIG_LOCK, d);
        `CHECK("config bits", 16'h003E, d)
        wr_reg(`OFS_TIMER_RELOAD, 16'h1234);
        rd_reg(`OFS_TIMER_RELOAD, d);
        `CHECK("locked reload", 16'h0000, d)
        rd_reg(`OFS_TICK_PRESCALER, d);
        `CHECK("locked prescaler", 16'h0000, d)
        rd_reg(`OFS_TIMER_CTRL, d);
        `CHECK("locked control", 16'h0000, d)
        wr_reg(`OFS_CONFIG_LOCK, 16'h0001);
        rd_reg(`OFS_CONFIG_LOCK, d);
        `CHECK("locked config", 16'h0000, d)
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset_values;
        t_periods;
        t_watchdog;
        t_locks;
        print_verdict;
    end
endmodule // test_timing_watchdog_unit
